// ===== kwd_pkg.sv
// Package for the keyed watchdog timer: register offsets, fields, keys, reset values.
// Assumes a 16-bit register port on the configuration region, byte offsets as printed.
package kwd_pkg;
   localparam logic [11:0] KWD_OFS_CTRL = 12'h0cb0;
   localparam logic [11:0] KWD_OFS_CNTL = 12'h0cb2;
   localparam logic [11:0] KWD_OFS_CNTH = 12'h0cb4;
   localparam int KWD_BIT_ENB = 15;
   localparam int KWD_BIT_RST = 14;
   localparam int KWD_BIT_FLG = 12;
   localparam logic [15:0] KWD_KEY_WR1 = 16'h3333;
   localparam logic [15:0] KWD_KEY_WR2 = 16'hcccc;
   localparam logic [15:0] KWD_KEY_CL1 = 16'haaaa;
   localparam logic [15:0] KWD_KEY_CL2 = 16'h5555;
   localparam logic KWD_RST_ENB = 1'h0;
   localparam logic KWD_RST_RSTSEL = 1'h1;
   localparam logic [7:0] KWD_RST_EXP = 8'h01;
   localparam logic [4:0] KWD_EXP_B0 = 5'h0e;
   localparam logic [4:0] KWD_EXP_B1 = 5'h18;
   typedef enum logic [1:0] {KWD_K_IDLE, KWD_K_WR1, KWD_K_CL1} kwd_key_e;
endpackage

// ===== kwd_top.sv
// Keyed watchdog timer: control register, two count registers, time-out actions.
// Assumes a simple 16-bit register port on clk_sys; debug_mode comes from the
// CPU on the same clock. Reset output and indicator are one-cycle pulses.
//
// Summary of operation
// - Enabling zeroes count, starts, locks configuration
// - Interrupt mode: first time-out flags, second resets
// - Reset mode: every time-out resets
// - Interrupt-mode time-out sets flag; write one clears
// - Flag clearable while running and locked
// - Period is two to exponent clocks
// - Bit0 gives 14, bits1-7 give 24-30
// - Lowest set exponent bit wins
// - Write key opens one control write
// - Clear-count key zeroes the counter
// - Keys recognised only at control offset
// - Register relocks after the single write
// - Action and exponent writable only when stopped
// - Debug mode freezes counter
// - Count low returns bits 15-0
// - Count high returns bits 30-16, bit15 zero
// - Wide reads split into two accesses
// - Watchdog reset sets reset indicator
`timescale 1ns/1ps
module kwd_top
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic debug_mode,
   output logic [15:0] reg_rdata,
   output logic irq_req,
   output logic sys_reset_req,
   output logic watchdog_reset_indicator
);
////////////////////////////////////////////////////////////////////////////////
   logic run_enable_r;
   logic reset_action_select_r;
   logic timeout_interrupt_flag_r;
   logic [7:0] exponent_select_r;
   logic [30:0] count_r;
   logic [30:0] count_nxt;
   kwd_pkg::kwd_key_e key_r;
   kwd_pkg::kwd_key_e key_nxt;
   logic [15:0] rdata_nxt;

   wire ctl_wr = reg_wr && (reg_addr == kwd_pkg::KWD_OFS_CTRL);
   wire is_wr1 = (reg_wdata == kwd_pkg::KWD_KEY_WR1);
   wire is_wr2 = (reg_wdata == kwd_pkg::KWD_KEY_WR2);
   wire is_cl1 = (reg_wdata == kwd_pkg::KWD_KEY_CL1);
   wire is_cl2 = (reg_wdata == kwd_pkg::KWD_KEY_CL2);
   wire clear_key = ctl_wr && (key_r == kwd_pkg::KWD_K_CL1) && is_cl2;
   wire write_key = ctl_wr && (key_r == kwd_pkg::KWD_K_WR1) && is_wr2;
   wire is_key_word = is_wr1 || is_wr2 || is_cl1 || is_cl2;
   // Opened state is a sticky bit: a key word must not consume the single write
   logic open_r;
   wire cfg_wr = ctl_wr && open_r && !is_key_word;
   wire cfg_unlocked = cfg_wr && !run_enable_r;
   wire flag_clr = ctl_wr && !is_key_word && reg_wdata[kwd_pkg::KWD_BIT_FLG];
   wire start = cfg_wr && !run_enable_r && reg_wdata[kwd_pkg::KWD_BIT_ENB];
////////////////////////////////////////////////////////////////////////////////
   // Lowest set bit picks the exponent; zero field means never
   logic [4:0] exp_val;
   logic exp_valid;
   always_comb
   begin
      exp_val = '0;
      exp_valid = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         if (exponent_select_r[i])
         begin
            exp_valid = 1'b1;
            exp_val = (i == 0) ? kwd_pkg::KWD_EXP_B0
                               : 5'(kwd_pkg::KWD_EXP_B1 + 5'(i - 1));
         end
      end
   end
   // Limit is only meaningful while exp_valid is high; an empty field never times out
   wire [30:0] limit = 31'(32'h0000_0001 << exp_val);
   wire counting = run_enable_r && !debug_mode;
   wire timeout = counting && exp_valid && (count_r == limit - 31'h0000_0001);
   wire to_reset = timeout && (reset_action_select_r || timeout_interrupt_flag_r);
   wire to_irq = timeout && !to_reset;

   always_comb
   begin
      count_nxt = count_r;
      if (start || clear_key || timeout)
         count_nxt = '0;
      else if (counting)
         count_nxt = count_r + 31'h0000_0001;
   end

   // Stray writes at the control offset abandon a half-entered key
   always_comb
   begin
      key_nxt = key_r;
      if (ctl_wr)
      begin
         if (is_wr1)
            key_nxt = kwd_pkg::KWD_K_WR1;
         else if (is_cl1)
            key_nxt = kwd_pkg::KWD_K_CL1;
         else
            key_nxt = kwd_pkg::KWD_K_IDLE;
      end
   end

   // Count words are read as separate 16-bit halves, so no snapshot is kept
   wire [15:0] ctl_view = {run_enable_r, reset_action_select_r, 1'b0,
                           timeout_interrupt_flag_r, 4'h0, exponent_select_r};
   always_comb
   begin
      rdata_nxt = 16'h0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            kwd_pkg::KWD_OFS_CTRL: rdata_nxt = ctl_view;
            kwd_pkg::KWD_OFS_CNTL: rdata_nxt = count_r[15:0];
            kwd_pkg::KWD_OFS_CNTH: rdata_nxt = {1'b0, count_r[30:16]};
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end
////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         run_enable_r <= kwd_pkg::KWD_RST_ENB;
         reset_action_select_r <= kwd_pkg::KWD_RST_RSTSEL;
         exponent_select_r <= kwd_pkg::KWD_RST_EXP;
         timeout_interrupt_flag_r <= 1'b0;
         count_r <= '0;
         key_r <= kwd_pkg::KWD_K_IDLE;
         open_r <= 1'b0;
         reg_rdata <= 16'h0000;
         irq_req <= 1'b0;
         sys_reset_req <= 1'b0;
         watchdog_reset_indicator <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         key_r <= key_nxt;
         reg_rdata <= rdata_nxt;
         if (write_key)
            open_r <= 1'b1;
         else if (cfg_wr)
            open_r <= 1'b0;
         if (cfg_wr)
            run_enable_r <= reg_wdata[kwd_pkg::KWD_BIT_ENB];
         if (cfg_unlocked)
         begin
            reset_action_select_r <= reg_wdata[kwd_pkg::KWD_BIT_RST];
            exponent_select_r <= reg_wdata[7:0];
         end
         // Set wins over a clear in the same cycle
         if (to_irq)
            timeout_interrupt_flag_r <= 1'b1;
         else if (flag_clr)
            timeout_interrupt_flag_r <= 1'b0;
         irq_req <= to_irq;
         sys_reset_req <= to_reset;
         watchdog_reset_indicator <= to_reset;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   a_irq_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
      to_irq |=> timeout_interrupt_flag_r && irq_req)
      else $error("Interrupt time-out did not set the flag");
   a_second_resets: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (timeout && timeout_interrupt_flag_r) |=> sys_reset_req && !irq_req)
      else $error("Second time-out did not reset");
   a_reset_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (timeout && reset_action_select_r) |=> sys_reset_req)
      else $error("Reset mode time-out did not reset");
   a_start_zeroes: assert property (@(posedge clk_sys) disable iff (!rst_b)
      start |=> run_enable_r && count_r == 31'h0000_0000)
      else $error("Enable did not zero the count");
   a_locked_cfg: assert property (@(posedge clk_sys) disable iff (!rst_b)
      run_enable_r |=> $stable(exponent_select_r) && $stable(reset_action_select_r))
      else $error("Configuration changed while running");
   a_clear_key: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clear_key |=> count_r == 31'h0000_0000)
      else $error("Clear key did not zero the count");
   a_debug_freeze: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (debug_mode && !start && !clear_key) |=> $stable(count_r) && !irq_req && !sys_reset_req)
      else $error("Counter moved in debug mode");
   a_unkeyed_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (ctl_wr && !open_r) |=> $stable(run_enable_r))
      else $error("Unkeyed write changed the enable");
   a_min_period: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (timeout && exponent_select_r[0]) |-> count_r == 31'h0000_3fff)
      else $error("Bit zero period is not two to fourteen");
////////////////////////////////////////////////////////////////////////////////
   // Further checks on flag handling, key decoding, counting and the read port.
   // Long exponents are never reached in short runs; those checks guard the decode.

   // A clear without a competing time-out empties the flag
   a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (flag_clr && !to_irq) |=> !timeout_interrupt_flag_r)
      else $error("Flag clear was not taken");

   // Without a set or a clear the flag keeps its value
   a_flag_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!flag_clr && !to_irq) |=> $stable(timeout_interrupt_flag_r))
      else $error("Flag changed on its own");

   // Locked and running, the flag still clears
   a_flag_running: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (run_enable_r && !open_r && flag_clr && !to_irq) |=> !timeout_interrupt_flag_r)
      else $error("Flag clear refused while running");

   // An interrupt only comes from interrupt mode with the flag clear
   a_irq_first: assert property (@(posedge clk_sys) disable iff (!rst_b)
      to_irq |-> !timeout_interrupt_flag_r && !reset_action_select_r)
      else $error("Interrupt raised where a reset was due");

   // The two actions never fire together
   a_one_action: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !(irq_req && sys_reset_req))
      else $error("Interrupt and reset in one cycle");

   // The indicator follows every watchdog reset
   a_indicator_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
      sys_reset_req |-> watchdog_reset_indicator)
      else $error("Reset without indicator");

   // And never shows without one
   a_indicator_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
      watchdog_reset_indicator |-> sys_reset_req)
      else $error("Indicator without reset");

   // Every time-out restarts the count
   a_count_restart: assert property (@(posedge clk_sys) disable iff (!rst_b)
      timeout |=> count_r == 31'h0000_0000)
      else $error("Count did not restart after time-out");

   // One step per clock while counting
   a_count_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (counting && !timeout && !start && !clear_key)
      |=> count_r == 31'($past(count_r) + 31'h0000_0001))
      else $error("Count did not step by one");

   // A stopped watchdog neither counts nor acts
   a_stopped_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!run_enable_r && !start && !clear_key) |=> $stable(count_r))
      else $error("Count moved while stopped");

   a_stopped_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !run_enable_r |=> !irq_req && !sys_reset_req)
      else $error("Action while stopped");

   // An empty exponent field never times out
   a_never_timeout: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (exponent_select_r == 8'h00) |-> !timeout)
      else $error("Time-out with empty exponent field");

   // Top bit alone gives the longest period
   a_exp_top: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (timeout && exponent_select_r == 8'h80) |-> count_r == 31'h3fff_ffff)
      else $error("Top exponent period wrong");

   // Bit one wins over higher bits
   a_lowest_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (timeout && exponent_select_r[1:0] == 2'b10) |-> count_r == 31'h00ff_ffff)
      else $error("Lowest exponent bit did not win");

   // The write key opens the register
   a_open_by_key: assert property (@(posedge clk_sys) disable iff (!rst_b)
      write_key |=> open_r)
      else $error("Write key did not open the register");

   // The single admitted write closes it again
   a_open_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
      cfg_wr |=> !open_r)
      else $error("Register stayed open after its write");

   // A word that starts no key drops a pending one
   a_key_abandon: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (ctl_wr && !is_wr1 && !is_cl1) |=> key_r == kwd_pkg::KWD_K_IDLE)
      else $error("Stray write kept a pending key");

   // Other offsets leave the key state alone
   a_key_offset: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !ctl_wr |=> $stable(key_r))
      else $error("Key state moved without a control write");

   // A stopped, opened write loads action and exponent
   a_stopped_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
      cfg_unlocked |=> exponent_select_r == $past(reg_wdata[7:0])
         && reset_action_select_r == $past(reg_wdata[kwd_pkg::KWD_BIT_RST]))
      else $error("Opened write did not load the configuration");

   // Closed register keeps action and exponent
   a_unkeyed_cfg: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (ctl_wr && !open_r) |=> $stable(exponent_select_r) && $stable(reset_action_select_r))
      else $error("Unkeyed write changed the configuration");

   // Count low returns the low count bits
   a_read_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (reg_rd && reg_addr == kwd_pkg::KWD_OFS_CNTL) |=> reg_rdata == $past(count_r[15:0]))
      else $error("Count low read wrong");

   // Count high returns the upper bits with bit 15 zero
   a_read_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (reg_rd && reg_addr == kwd_pkg::KWD_OFS_CNTH)
      |=> reg_rdata == {1'b0, $past(count_r[30:16])})
      else $error("Count high read wrong");

   // Control read shows the flag and zero reserved bits
   a_read_ctl: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (reg_rd && reg_addr == kwd_pkg::KWD_OFS_CTRL)
      |=> reg_rdata[12] == $past(timeout_interrupt_flag_r) && reg_rdata[13] == 1'b0
         && reg_rdata[11:8] == 4'h0 && reg_rdata[15] == $past(run_enable_r))
      else $error("Control read wrong");

   // Idle read port returns zero
   a_read_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("Read data without a read");

   // Main scenarios that the bench is expected to reach
   c_second: cover property (@(posedge clk_sys) disable iff (!rst_b)
      to_reset && !reset_action_select_r);
   c_irq: cover property (@(posedge clk_sys) disable iff (!rst_b) to_irq);
   c_reset: cover property (@(posedge clk_sys) disable iff (!rst_b) to_reset);
   c_start: cover property (@(posedge clk_sys) disable iff (!rst_b) start);
   c_clear: cover property (@(posedge clk_sys) disable iff (!rst_b) clear_key);
endmodule

// ===== keyed_watchdog_timer_tb.sv
// Self-checking bench for the keyed watchdog timer top level.
// Assumes kwd_top with a registered read port and one-cycle action pulses.
`timescale 1ns/1ps
module keyed_watchdog_timer_tb;
   logic clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, debug_mode = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [15:0] reg_wdata = 16'h0000, d, e;
   logic [15:0] reg_rdata;
   logic irq_req, sys_reset_req, watchdog_reset_indicator;
   int bad_count = 0, tests_run = 0, cyc = 0;
   kwd_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .debug_mode(debug_mode),
      .reg_rdata(reg_rdata), .irq_req(irq_req), .sys_reset_req(sys_reset_req),
      .watchdog_reset_indicator(watchdog_reset_indicator));
   initial forever #20 clk_sys = ~clk_sys;
   // Ceiling allows three 2^14 time-outs plus register traffic
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         bad_count++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] y);
      tests_run++;
      if (y !== x)
      begin
         $display("unexpected %s expected %h seen %h", n, x, y);
         bad_count++;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic ctl(input logic [15:0] x);
      rd(12'hcb0);
      chk("control", x, d);
   endtask
   // Full write key, then the one data word it admits
   task automatic kw(input logic [15:0] v);
      wr(12'hcb0, 16'h3333);
      wr(12'hcb0, 16'hcccc);
      wr(12'hcb0, v);
   endtask
   task automatic pulse(output logic r);
      int k;
      k = 0;
      while (k < 20000 && irq_req !== 1'b1 && sys_reset_req !== 1'b1)
      begin
         @(posedge clk_sys);
         #1 k++;
      end
      r = sys_reset_req;
      chk("pulse wait", 16'h0001, 16'(k < 20000));
      chk("indicator", {15'h0000, r}, {15'h0000, watchdog_reset_indicator});
   endtask
   function automatic int period(input logic [7:0] s);
      for (int i = 0; i < 8; i++)
         if (s[i])
            return 1 << ((i == 0) ? 14 : 23 + i);
      return 0;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic r;
      int tp;
      void'($urandom(32'h13b4));
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      ctl(16'h4001);
      repeat (4)
      begin
         e = $urandom;
         if (e inside {16'h3333, 16'hcccc, 16'haaaa, 16'h5555}) e = 16'h8080;
         wr(12'hcb0, e);
         wr(12'hcb2, 16'h3333);
         ctl(16'h4001);
      end
      wr(12'hcb2, 16'h3333);
      wr(12'hcb0, 16'hcccc);
      wr(12'hcb0, 16'h0001);
      ctl(16'h4001);
      wr(12'hcb0, 16'h3333);
      wr(12'hcb0, 16'haaaa);
      wr(12'hcb0, 16'hcccc);
      wr(12'hcb0, 16'h0001);
      ctl(16'h4001);
      kw(16'h0001);
      ctl(16'h0001);
      kw(16'h0002);
      wr(12'hcb0, 16'h0004);
      ctl(16'h0002);
      kw(16'h0003);
      kw(16'h8003);
      rd(12'hcb2);
      chk("count after enable", 16'h0001, 16'(d < 16));
      pulse(r);
      chk("first action", 16'h0000, 16'(r));
      tp = cyc;
      ctl(16'h9003);
      pulse(r);
      chk("second action", 16'h0001, 16'(r));
      chk("period", 16'(period(8'h03)), 16'(cyc - tp));
      wr(12'hcb0, 16'h1000);
      ctl(16'h8003);
      kw(16'h8004);
      ctl(16'h8003);
      wr(12'hcb0, 16'haaaa);
      wr(12'hcb0, 16'h5555);
      rd(12'hcb2);
      chk("cleared count", 16'h0001, 16'(d < 16));
      debug_mode <= 1'b1;
      rd(12'hcb4);
      chk("count high", 16'h0000, d);
      rd(12'hcb2);
      e = d;
      repeat (20) @(posedge clk_sys);
      rd(12'hcb2);
      chk("frozen count", e, d);
      debug_mode <= 1'b0;
      kw(16'h0001);
      kw(16'hc001);
      ctl(16'hc001);
      pulse(r);
      chk("reset mode action", 16'h0001, 16'(r));
      report_and_stop();
   end
endmodule
